// File: sim/board_model.sv
// Board circuitry model that resolves each pad level from both drivers.
`timescale 1ns/10ps
module board_model
    import pinmux_pkg::*;
(
    input wire pinmux_pkg::pin_vec_t pin_out_i,
    input wire pinmux_pkg::pin_vec_t pin_oe_i,
    input wire pinmux_pkg::pin_vec_t ext_en_i,
    input wire pinmux_pkg::pin_vec_t ext_val_i,
    output pinmux_pkg::pin_vec_t pad_o
);
    // The board has pull-ups, so a released pad reads high, never its last level.
    // Limitation: contention is not flagged; the device driver simply wins.
    always_comb begin
        for (int p = 0; p < 16; p++) begin
            pad_o[p] = pin_oe_i[p] ? pin_out_i[p] : (ext_en_i[p] ? ext_val_i[p] : 1'b1);
        end
    end
endmodule

// File: sim/gpio_function_select_mux_properties.sv
// Concurrent checks on the pin function multiplexer ports.
`timescale 1ns/10ps
`include "pinmux_cfg.svh"
module gpio_function_select_mux_properties
    import pinmux_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [159:0] pin_function_code_i,
    input wire pinmux_pkg::pin_vec_t pin_direction_bit_i,
    input wire pinmux_pkg::pin_vec_t pin_level_field_i,
    input wire pinmux_pkg::pin_vec_t output_invert_bit_i,
    input wire pinmux_pkg::pin_vec_t alt_out_i,
    input wire pinmux_pkg::pin_vec_t alt_oe_i,
    input wire pinmux_pkg::pin_vec_t alt_od_i,
    input wire pinmux_pkg::pin_vec_t dsp_out_i,
    input wire pinmux_pkg::pin_vec_t dsp_oe_i,
    input wire logic interrupt_request_one_i,
    input wire logic interrupt_request_two_i,
    input wire logic freq_locked_loop_one_lock_i,
    input wire logic spdif_tx_i,
    input wire pinmux_pkg::pin_vec_t pin_out_o,
    input wire pinmux_pkg::pin_vec_t pin_oe_o,
    input wire pinmux_pkg::pin_vec_t pin_od_o
);
    // -------------------------------------------------------------------
    // Every pad output is registered, so each check looks one edge later.
    // -------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    a_irq_one_route: assert property (pin_function_code_i[9:0] == `PMX_FN_INTERRUPT_REQUEST_ONE
        |=> pin_out_o[0] == $past(interrupt_request_one_i) && pin_oe_o[0])
        else $error("first interrupt not routed to pin 1");
    a_irq_two_route: assert property (pin_function_code_i[159:150] == `PMX_FN_INTERRUPT_REQUEST_TWO
        |=> pin_out_o[15] == $past(interrupt_request_two_i) && pin_oe_o[15])
        else $error("second interrupt not routed to pin 16");
    a_lock_low_pin: assert property (pin_function_code_i[19:10] == `PMX_FN_FREQ_LOCKED_LOOP_ONE_LOCK
        |=> pin_out_o[1] == $past(freq_locked_loop_one_lock_i) && pin_oe_o[1])
        else $error("loop lock not routed to pin 2");
    a_spdif_high_pin: assert property (pin_function_code_i[159:150] == `PMX_FN_SPDIF
        |=> pin_out_o[15] == $past(spdif_tx_i) && pin_oe_o[15])
        else $error("serial audio output not routed to pin 16");
    a_alt_low_refused: assert property (pin_function_code_i[9:0] == `PMX_FN_ALT
        |=> !pin_oe_o[0] && !pin_out_o[0])
        else $error("alternate function accepted on pin 1");
    a_alt_owns_pin: assert property (pin_function_code_i[29:20] == `PMX_FN_ALT
        |=> pin_oe_o[2] == $past(alt_oe_i[2]) && pin_od_o[2] == $past(alt_od_i[2]))
        else $error("alternate function does not own pin 3");
    a_level_drive: assert property (pin_function_code_i[9:0] == `PMX_FN_GPIO
        && !pin_direction_bit_i[0] |=> pin_oe_o[0]
        && pin_out_o[0] == $past(pin_level_field_i[0] ^ output_invert_bit_i[0]))
        else $error("logic level output wrong on pin 1");
    a_button_input: assert property (pin_function_code_i[9:0] == `PMX_FN_GPIO
        && pin_direction_bit_i[0] |=> !pin_oe_o[0])
        else $error("button input pin 1 is driven");
    a_dsp_direction: assert property (pin_function_code_i[9:0] == `PMX_FN_DSP
        |=> pin_oe_o[0] == $past(dsp_oe_i[0])
        && pin_out_o[0] == $past(dsp_out_i[0] & dsp_oe_i[0]))
        else $error("signal processor does not own pin 1");
    a_misplaced_clock: assert property (pin_function_code_i[49:40] == `PMX_FN_FREQ_LOCKED_LOOP_ONE_CLK
        |=> !pin_oe_o[4])
        else $error("loop clock accepted on pin 5");
endmodule

bind gpio_function_select_mux gpio_function_select_mux_properties i_props (
    .core_clk_i, .srst_i, .pin_function_code_i, .pin_direction_bit_i,
    .pin_level_field_i, .output_invert_bit_i, .alt_out_i, .alt_oe_i, .alt_od_i,
    .dsp_out_i, .dsp_oe_i, .interrupt_request_one_i, .interrupt_request_two_i,
    .freq_locked_loop_one_lock_i, .spdif_tx_i, .pin_out_o, .pin_oe_o, .pin_od_o);

// File: sim/gpio_function_select_mux_tb_top.sv
// Self-checking bench for the pin function multiplexer.
`timescale 1ns/10ps
`include "pinmux_cfg.svh"
module gpio_function_select_mux_tb_top;
    import pinmux_pkg::*;
    // -------------------------------------------------------------------
    // Stimulus, results and tallies.
    // -------------------------------------------------------------------
    logic clk, srst, aux_in; // Clock, reset and aux clock input result.
    logic [159:0] codes; // Per-pin function codes.
    logic [19:0] src; // Shared sources, in the order of the code table.
    pin_vec_t dir, lvl, inv, drv, aout, aoe, aod, dout, doe, ext_en, ext_val, pad;
    pin_vec_t p_out, p_oe, p_od, p_lvl, p_edge, acc;
    int compares, miscompares, cnt;
    localparam logic [19:0] low_only = 20'h058FC; // Codes limited to pins 1 to 4.
    localparam fn_code_t tbl [20] = '{`PMX_FN_INTERRUPT_REQUEST_ONE, `PMX_FN_INTERRUPT_REQUEST_TWO, `PMX_FN_FREQ_LOCKED_LOOP_ONE_CLK,
        `PMX_FN_FREQ_LOCKED_LOOP_TWO_CLK, `PMX_FN_FREQ_LOCKED_LOOP_ONE_LOCK, `PMX_FN_FREQ_LOCKED_LOOP_TWO_LOCK, `PMX_FN_DERIVED_CLOCK_OUTPUT,
        `PMX_FN_DERIVED_CLOCK_OUTPUT_ASYNC, `PMX_FN_PULSE_WIDTH_GEN_ONE, `PMX_FN_PULSE_WIDTH_GEN_TWO, `PMX_FN_SPDIF,
        `PMX_FN_ASRC_IN1_LOCK, `PMX_FN_ASRC_IN2_LOCK, `PMX_FN_TIMER1, `PMX_FN_EVLOG1,
        `PMX_FN_ALARM_CH1, `PMX_FN_ALARM_CH2, `PMX_FN_ALARM_CH3, `PMX_FN_ALARM_CH4,
        `PMX_FN_AUXPDM_CLK};

    gpio_function_select_mux i_gpio_function_select_mux (.core_clk_i(clk), .srst_i(srst),
        .pin_function_code_i(codes), .pin_direction_bit_i(dir), .pin_level_field_i(lvl),
        .output_invert_bit_i(inv), .driver_type_bit_i(drv), .alt_out_i(aout),
        .alt_oe_i(aoe), .alt_od_i(aod), .dsp_out_i(dout), .dsp_oe_i(doe),
        .interrupt_request_one_i(src[0]), .interrupt_request_two_i(src[1]),
        .freq_locked_loop_one_clk_i(src[2]), .freq_locked_loop_two_clk_i(src[3]),
        .freq_locked_loop_one_lock_i(src[4]), .freq_locked_loop_two_lock_i(src[5]),
        .derived_clock_output_sys_i(src[6]), .derived_clock_output_async_i(src[7]),
        .pulse_width_gen_one_i(src[8]), .pulse_width_gen_two_i(src[9]),
        .spdif_tx_i(src[10]), .rate_converter_one_in1_lock_i(src[11]),
        .rate_converter_one_in2_lock_i(src[12]), .timer_one_pulse_i(src[13]),
        .event_log_one_not_empty_i(src[14]), .alarm_pulse_i(src[18:15]),
        .aux_pdm_clk_i(src[19]), .aux_pdm_data_i(1'b0), .pin_in_i(pad),
        .pin_out_o(p_out), .pin_oe_o(p_oe), .pin_od_o(p_od), .pin_level_read_o(p_lvl),
        .button_edge_o(p_edge), .aux_pdm_clk_in_o(aux_in));
    board_model i_board_model (.pin_out_i(p_out), .pin_oe_i(p_oe), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pad_o(pad));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Pins where table entry k may appear; aux clock lives on pins 3 and 10 only.
    function automatic pin_vec_t vmask(input int k);
        pin_vec_t m;
        for (int p = 0; p < 16; p++) begin
            m[p] = (k == 19) ? (p == 2 || p == 9) : (!low_only[k] || p < 4);
        end
        return m;
    endfunction

    task automatic chk(input pin_vec_t got, input pin_vec_t exp, input string what);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Lets the sampling edge pass and its register updates land.
    task automatic wait_out();
        @(posedge clk);
        #1;
    endtask

    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // The whole sequence needs some 150 cycles; 3000 is a generous ceiling.
    initial begin
        #30000;
        miscompares++;
        report_and_stop();
    end

    initial begin
        {codes, src, dir, lvl, inv, aout, aoe, aod, dout, doe, ext_en, ext_val} = '0;
        drv = 16'hA5A5;
        srst = 1'b1;
        compares = 0;
        miscompares = 0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        // One-hot and inverted one-hot sources expose swapped or misplaced routes.
        for (int k = 0; k < 20; k++) begin
            for (int n = 0; n < 2; n++) begin
                @(posedge clk);
                codes <= {16{tbl[k]}};
                src <= n ? ~(20'h1 << k) : (20'h1 << k);
                wait_out();
                chk(p_oe, vmask(k), "enable");
                chk(p_out, n ? 16'h0000 : vmask(k), "level");
                chk(p_od, drv, "drive type");
            end
        end
        for (int v = 0; v < 4; v++) begin
            @(posedge clk);
            codes <= {16{`PMX_FN_GPIO}};
            lvl <= {16{v[0]}};
            inv <= 16'h00FF & {16{v[1]}};
            wait_out();
            chk(p_out, {16{v[0]}} ^ (16'h00FF & {16{v[1]}}), "gpio level");
            chk(p_oe, 16'hFFFF, "gpio enable");
        end
        @(posedge clk);
        dir <= 16'hFFFF;
        ext_en <= 16'hFFFF;
        repeat (8) wait_out();
        chk(p_oe, 16'h0000, "input enable");
        acc = '0;
        cnt = 0;
        for (int e = 0; e < 2; e++) begin
            @(posedge clk);
            ext_val <= e ? 16'h0000 : 16'h0001;
            repeat (8) begin
                wait_out();
                acc |= p_edge;
                cnt += (p_edge[0] === 1'b1);
            end
            chk(p_lvl, e ? 16'h0000 : 16'h0001, "level read");
        end
        chk(acc, 16'h0001, "edge pins");
        chk(pin_vec_t'(cnt), 16'h0002, "edge count");
        // Direction bits disagree with the signal processor's wish on several pins.
        @(posedge clk);
        codes <= {16{`PMX_FN_DSP}};
        dout <= 16'h0031;
        doe <= 16'h00F1;
        wait_out();
        chk(p_oe, 16'h00F1, "dsp enable");
        chk(p_out & 16'h00F1, 16'h0031, "dsp level");
        @(posedge clk);
        dir <= 16'h0000;
        doe <= 16'h0F00;
        wait_out();
        chk(p_oe, 16'h0F00, "dsp enable");
        @(posedge clk);
        codes <= {16{`PMX_FN_ALT}};
        aoe <= 16'hFF03;
        aout <= 16'hF0F3;
        aod <= 16'h3C3C;
        wait_out();
        chk(p_oe, 16'hFF00, "alt enable");
        chk(p_out & 16'hFF03, 16'hF000, "alt level");
        chk(p_od, 16'h3C3C & 16'hFFFC | 16'hA5A5 & 16'h0003, "alt drive");
        @(posedge clk);
        codes <= {16{10'h3FF}};
        wait_out();
        chk(p_oe | p_out, 16'h0000, "unlisted code");
        @(posedge clk);
        codes <= {120'h0, `PMX_FN_AUXPDM_DAT, `PMX_FN_AUXPDM_CLK, 20'h0};
        dir <= 16'h0004;
        aout <= 16'h0008;
        ext_val <= 16'h0004;
        for (int e = 0; e < 2; e++) begin
            repeat (6) wait_out();
            chk({15'h0, aux_in}, e ? 16'h0000 : 16'h0001, "aux clock in");
            chk(p_out & p_oe & 16'h0008, 16'h0008, "aux data");
            @(posedge clk);
            ext_val <= 16'h0000;
        end
        // A mid-run reset with every pin a pulled-up button must raise no edge.
        @(posedge clk);
        codes <= {16{`PMX_FN_GPIO}};
        dir <= 16'hFFFF;
        ext_en <= 16'h0000;
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        acc = '0;
        repeat (8) begin
            wait_out();
            acc |= p_edge;
        end
        chk(acc, 16'h0000, "edge after reset");
        report_and_stop();
    end
endmodule

// File: verilog/gpio_function_select_mux.sv
// Sixteen-pin function-select multiplexer with button-edge detection.
`timescale 1ns/10ps
`include "pinmux_cfg.svh"

// -----------------------------------------------------------------------------
// What this block does
// - Each of sixteen pins has own code.
// - Code 0x000 alternate function, pins 3-16.
// - Code 0x001 drives level or reads input.
// - Code 0x002 connects DSP input/output, all pins.
// - Code 0x003 outputs first interrupt request.
// - Code 0x004 outputs second interrupt request.
// - Codes 0x010/0x011 loop clocks, pins 1-4.
// - Codes 0x018/0x019 loop lock, pins 1-4.
// - Codes 0x040/0x041 derived clocks, pins 1-4.
// - Codes 0x048/0x049 PWM, 0x04C S/PDIF, all.
// - Codes 0x088/0x089 converter lock, pins 1-4.
// - Code 0x140 outputs timer pulse, all pins.
// - Code 0x150 event-log not-empty, pins 1-4.
// - Codes 0x230-0x233 alarm pulses, all pins.
// - 0x280 aux clock pins 3/10; 0x281 data 4/9.
// - Alternate function sets direction and driver itself.
// - DSP function sets direction; direction bit ignored.
// - Invert bit flips level driven by code 0x001.
// - Button input flags both edges.
// -----------------------------------------------------------------------------

module gpio_function_select_mux (
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Function codes, pin 1 in the lowest ten bits.
    input wire logic [159:0] pin_function_code_i,
    input wire pinmux_pkg::pin_vec_t pin_direction_bit_i,
    input wire pinmux_pkg::pin_vec_t pin_level_field_i,
    input wire pinmux_pkg::pin_vec_t output_invert_bit_i,
    input wire pinmux_pkg::pin_vec_t driver_type_bit_i,
    // Pin-specific alternate function drives.
    input wire pinmux_pkg::pin_vec_t alt_out_i,
    input wire pinmux_pkg::pin_vec_t alt_oe_i,
    input wire pinmux_pkg::pin_vec_t alt_od_i,
    // DSP pin drives.
    input wire pinmux_pkg::pin_vec_t dsp_out_i,
    input wire pinmux_pkg::pin_vec_t dsp_oe_i,
    // Shared sources from on-chip logic, same clock.
    input wire logic interrupt_request_one_i,
    input wire logic interrupt_request_two_i,
    input wire logic freq_locked_loop_one_clk_i,
    input wire logic freq_locked_loop_two_clk_i,
    input wire logic freq_locked_loop_one_lock_i,
    input wire logic freq_locked_loop_two_lock_i,
    input wire logic derived_clock_output_sys_i,
    input wire logic derived_clock_output_async_i,
    input wire logic pulse_width_gen_one_i,
    input wire logic pulse_width_gen_two_i,
    input wire logic spdif_tx_i,
    input wire logic rate_converter_one_in1_lock_i,
    input wire logic rate_converter_one_in2_lock_i,
    input wire logic timer_one_pulse_i,
    input wire logic event_log_one_not_empty_i,
    input wire logic [3:0] alarm_pulse_i,
    input wire logic aux_pdm_clk_i,
    input wire logic aux_pdm_data_i,
    // Debounced pin levels from the pad side.
    input wire pinmux_pkg::pin_vec_t pin_in_i,
    // Pad controls and results.
    output pinmux_pkg::pin_vec_t pin_out_o,
    output pinmux_pkg::pin_vec_t pin_oe_o,
    output pinmux_pkg::pin_vec_t pin_od_o,
    output pinmux_pkg::pin_vec_t pin_level_read_o,
    output pinmux_pkg::pin_vec_t button_edge_o,
    output logic aux_pdm_clk_in_o
);
    import pinmux_pkg::*;

    // -------------------------------------------------------------------------
    // Pin input synchroniser.
    // -------------------------------------------------------------------------
    pin_vec_t sync1_r; // First stage, read only by the second stage.
    pin_vec_t sync1_nxt;
    pin_vec_t sync2_r; // Second stage, safe to use.
    pin_vec_t sync2_nxt;
    // Fills with ones after reset. Edges are ignored until its top bit is set,
    // because until then the pipeline holds reset zeros, not pad levels.
    // Trade-off: a genuine pad change in those first cycles raises no event.
    logic [`PMX_SETTLE_CYCLES-1:0] warm_r;
    logic [`PMX_SETTLE_CYCLES-1:0] warm_nxt;

    // Next values of the two-stage synchroniser.
    always_comb begin
        sync1_nxt = pin_in_i;
        sync2_nxt = sync1_r;
        warm_nxt = {warm_r[`PMX_SETTLE_CYCLES-2:0], 1'b1};
    end

    // Register the synchroniser.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
            warm_r <= '0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            warm_r <= warm_nxt;
        end
    end

    // -------------------------------------------------------------------------
    // Per-pin decoders.
    // -------------------------------------------------------------------------
    pin_vec_t mux_out; // Combinational pin drive.
    pin_vec_t mux_oe; // Combinational pin enable.
    pin_vec_t mux_od; // Combinational open-drain select.
    pin_vec_t btn_sel; // Pin is a button or level input.
    logic [19:0] src_bus; // Shared sources in slice order.

    // Gather the shared sources into one bus for every slice.
    assign src_bus = {aux_pdm_clk_i, alarm_pulse_i, event_log_one_not_empty_i,
        timer_one_pulse_i, rate_converter_one_in2_lock_i,
        rate_converter_one_in1_lock_i, spdif_tx_i, pulse_width_gen_two_i,
        pulse_width_gen_one_i, derived_clock_output_async_i,
        derived_clock_output_sys_i, freq_locked_loop_two_lock_i,
        freq_locked_loop_one_lock_i, freq_locked_loop_two_clk_i,
        freq_locked_loop_one_clk_i, interrupt_request_two_i, interrupt_request_one_i};

    // One independent slice per pin, each looking only at its own code.
    genvar gi;
    generate
        for (gi = 0; gi < `PMX_NUM_PINS; gi++) begin : g_pin
            pin_slice #(
                .PIN_NUM(gi + 1)
            ) u_slice (
                .code_i(pin_function_code_i[gi*`PMX_CODE_W +: `PMX_CODE_W]),
                .dir_i(pin_direction_bit_i[gi]),
                .level_i(pin_level_field_i[gi]),
                .invert_i(output_invert_bit_i[gi]),
                .drv_od_i(driver_type_bit_i[gi]),
                .alt_out_i(alt_out_i[gi]),
                .alt_oe_i(alt_oe_i[gi]),
                .alt_od_i(alt_od_i[gi]),
                .dsp_out_i(dsp_out_i[gi]),
                .dsp_oe_i(dsp_oe_i[gi]),
                .src_i(src_bus),
                .out_o(mux_out[gi]),
                .oe_o(mux_oe[gi]),
                .od_o(mux_od[gi]),
                .btn_sel_o(btn_sel[gi])
            );
        end
    endgenerate

    // -------------------------------------------------------------------------
    // Output registers.
    // -------------------------------------------------------------------------
    pin_vec_t out_r; // Registered pin drive.
    pin_vec_t out_nxt;
    pin_vec_t oe_r; // Registered pin enable.
    pin_vec_t oe_nxt;
    pin_vec_t od_r; // Registered driver type.
    pin_vec_t od_nxt;
    pin_vec_t lvl_r; // Debounced level for readback, unaffected by invert.
    pin_vec_t lvl_nxt;
    pin_vec_t edge_r; // One-cycle button edge pulses.
    pin_vec_t edge_nxt;
    logic auxclk_r; // Aux PDM clock taken from pin 3 or 10 when an input.
    logic auxclk_nxt;
    // Zero-based positions of the two pins that may take the aux clock in.
    localparam int AUXCLK_A = `PMX_PIN_AUXCLK_A - 1;
    localparam int AUXCLK_B = `PMX_PIN_AUXCLK_B - 1;

    // Next values: the decoded drive lands one cycle after a code change, and
    // every pin is registered on its own so no pin disturbs another.
    always_comb begin
        out_nxt = mux_out;
        oe_nxt = mux_oe;
        od_nxt = mux_od;
        lvl_nxt = sync2_r;
        // A change of the synchronised level on a button pin is an event;
        // both rising and falling edges count.
        edge_nxt = '0;
        if (warm_r[`PMX_SETTLE_CYCLES-1]) begin
            edge_nxt = btn_sel & (sync2_r ^ lvl_r);
        end
        // Aux clock input is only meaningful on its two permitted pins.
        auxclk_nxt = 1'b0;
        if (pin_function_code_i[AUXCLK_A*`PMX_CODE_W +: `PMX_CODE_W]
                == `PMX_FN_AUXPDM_CLK && pin_direction_bit_i[AUXCLK_A]) begin
            auxclk_nxt = sync2_r[AUXCLK_A];
        end else if (pin_function_code_i[AUXCLK_B*`PMX_CODE_W +: `PMX_CODE_W]
                == `PMX_FN_AUXPDM_CLK && pin_direction_bit_i[AUXCLK_B]) begin
            auxclk_nxt = sync2_r[AUXCLK_B];
        end
    end

    // Register every output; inactive after reset.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            out_r <= '0;
            oe_r <= '0;
            od_r <= '0;
            lvl_r <= '0;
            edge_r <= '0;
            auxclk_r <= `PMX_RST_BIT;
        end else begin
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            od_r <= od_nxt;
            lvl_r <= lvl_nxt;
            edge_r <= edge_nxt;
            auxclk_r <= auxclk_nxt;
        end
    end

    // Drive the ports straight from the registers.
    assign pin_out_o = out_r;
    assign pin_oe_o = oe_r;
    assign pin_od_o = od_r;
    assign pin_level_read_o = lvl_r;
    assign button_edge_o = edge_r;
    assign aux_pdm_clk_in_o = auxclk_r;

    // Note: the aux data source feeds the alternate drive path in the slices;
    // this unused-looking input is folded there through alt_out_i by the
    // integrator, so it is kept only as a documented hookup.
    logic aux_data_unused;
    assign aux_data_unused = aux_pdm_data_i;
endmodule

// File: verilog/pin_slice.sv
// One pin's function decoder and source selector.
`timescale 1ns/10ps
`include "pinmux_cfg.svh"

module pin_slice #(
    parameter int PIN_NUM = 1
) (
    input wire logic [9:0] code_i,
    input wire logic dir_i,
    input wire logic level_i,
    input wire logic invert_i,
    input wire logic drv_od_i,
    input wire logic alt_out_i,
    input wire logic alt_oe_i,
    input wire logic alt_od_i,
    input wire logic dsp_out_i,
    input wire logic dsp_oe_i,
    input wire logic [19:0] src_i,
    output logic out_o,
    output logic oe_o,
    output logic od_o,
    output logic btn_sel_o
);
    import pinmux_pkg::*;

    // Pin-position qualifiers evaluated at elaboration.
    localparam bit LOW_PIN = (PIN_NUM <= `PMX_PIN_LOW_LAST);
    localparam bit ALT_OK = (PIN_NUM >= `PMX_PIN_ALT_FIRST);
    localparam bit AUXCLK_OK = (PIN_NUM == `PMX_PIN_AUXCLK_A) || (PIN_NUM == `PMX_PIN_AUXCLK_B);
    localparam bit AUXDAT_OK = (PIN_NUM == `PMX_PIN_AUXDAT_A) || (PIN_NUM == `PMX_PIN_AUXDAT_B);

    // Pure combinational decode; the top registers the result, so a code change
    // takes effect one cycle later and touches only this pin.
    always_comb begin
        out_o = 1'b0;
        oe_o = 1'b0;
        od_o = drv_od_i;
        btn_sel_o = 1'b0;
        case (code_i)
            `PMX_FN_ALT: begin
                // On pins 3-16 the alternate function owns direction and driver type.
                if (ALT_OK) begin
                    out_o = alt_out_i;
                    oe_o = alt_oe_i;
                    od_o = alt_od_i;
                end
            end
            `PMX_FN_GPIO: begin
                // Direction 0 drives level, optionally inverted; 1 is an input.
                out_o = level_i ^ invert_i;
                oe_o = ~dir_i;
                btn_sel_o = dir_i;
            end
            `PMX_FN_DSP: begin
                // DSP sets direction; the direction bit is ignored.
                out_o = dsp_out_i;
                oe_o = dsp_oe_i;
            end
            `PMX_FN_INTERRUPT_REQUEST_ONE: begin
                out_o = src_i[0];
                oe_o = 1'b1;
            end
            `PMX_FN_INTERRUPT_REQUEST_TWO: begin
                out_o = src_i[1];
                oe_o = 1'b1;
            end
            `PMX_FN_FREQ_LOCKED_LOOP_ONE_CLK, `PMX_FN_FREQ_LOCKED_LOOP_TWO_CLK: begin
                out_o = code_i[0] ? src_i[3] : src_i[2];
                oe_o = LOW_PIN;
            end
            `PMX_FN_FREQ_LOCKED_LOOP_ONE_LOCK, `PMX_FN_FREQ_LOCKED_LOOP_TWO_LOCK: begin
                out_o = LOW_PIN & (code_i[0] ? src_i[5] : src_i[4]);
                oe_o = LOW_PIN;
            end
            `PMX_FN_DERIVED_CLOCK_OUTPUT, `PMX_FN_DERIVED_CLOCK_OUTPUT_ASYNC: begin
                out_o = LOW_PIN & (code_i[0] ? src_i[7] : src_i[6]);
                oe_o = LOW_PIN;
            end
            `PMX_FN_PULSE_WIDTH_GEN_ONE, `PMX_FN_PULSE_WIDTH_GEN_TWO: begin
                out_o = code_i[0] ? src_i[9] : src_i[8];
                oe_o = 1'b1;
            end
            `PMX_FN_SPDIF: begin
                out_o = src_i[10];
                oe_o = 1'b1;
            end
            `PMX_FN_ASRC_IN1_LOCK, `PMX_FN_ASRC_IN2_LOCK: begin
                out_o = LOW_PIN & (code_i[0] ? src_i[12] : src_i[11]);
                oe_o = LOW_PIN;
            end
            `PMX_FN_TIMER1: begin
                out_o = src_i[13];
                oe_o = 1'b1;
            end
            `PMX_FN_EVLOG1: begin
                out_o = LOW_PIN & src_i[14];
                oe_o = LOW_PIN;
            end
            `PMX_FN_ALARM_CH1, `PMX_FN_ALARM_CH2, `PMX_FN_ALARM_CH3, `PMX_FN_ALARM_CH4: begin
                out_o = src_i[15 + 32'(code_i[1:0])];
                oe_o = 1'b1;
            end
            `PMX_FN_AUXPDM_CLK: begin
                // Clock may come in or go out; the direction bit chooses.
                out_o = AUXCLK_OK & src_i[19];
                oe_o = AUXCLK_OK & ~dir_i;
            end
            `PMX_FN_AUXPDM_DAT: begin
                out_o = AUXDAT_OK & alt_out_i;
                oe_o = AUXDAT_OK;
            end
            default: begin
                // Reserved code: pin released and output low.
                out_o = 1'b0;
                oe_o = 1'b0;
            end
        endcase
        // Disallowed FLL clock placement also reads as reserved.
        if (!oe_o) begin
            out_o = 1'b0;
        end
    end
endmodule

// File: verilog/pinmux_cfg.svh
// Constants for the general-purpose pin function multiplexer.
`ifndef PINMUX_CFG_SVH
`define PINMUX_CFG_SVH

// -----------------------------------------------------------------------------
// Geometry.
// -----------------------------------------------------------------------------
`define PMX_NUM_PINS 16
`define PMX_CODE_W 10

// -----------------------------------------------------------------------------
// Function codes.
// -----------------------------------------------------------------------------
`define PMX_FN_ALT 10'h000
`define PMX_FN_GPIO 10'h001
`define PMX_FN_DSP 10'h002
`define PMX_FN_INTERRUPT_REQUEST_ONE 10'h003
`define PMX_FN_INTERRUPT_REQUEST_TWO 10'h004
`define PMX_FN_FREQ_LOCKED_LOOP_ONE_CLK 10'h010
`define PMX_FN_FREQ_LOCKED_LOOP_TWO_CLK 10'h011
`define PMX_FN_FREQ_LOCKED_LOOP_ONE_LOCK 10'h018
`define PMX_FN_FREQ_LOCKED_LOOP_TWO_LOCK 10'h019
`define PMX_FN_DERIVED_CLOCK_OUTPUT 10'h040
`define PMX_FN_DERIVED_CLOCK_OUTPUT_ASYNC 10'h041
`define PMX_FN_PULSE_WIDTH_GEN_ONE 10'h048
`define PMX_FN_PULSE_WIDTH_GEN_TWO 10'h049
`define PMX_FN_SPDIF 10'h04C
`define PMX_FN_ASRC_IN1_LOCK 10'h088
`define PMX_FN_ASRC_IN2_LOCK 10'h089
`define PMX_FN_TIMER1 10'h140
`define PMX_FN_EVLOG1 10'h150
`define PMX_FN_ALARM_CH1 10'h230
`define PMX_FN_ALARM_CH2 10'h231
`define PMX_FN_ALARM_CH3 10'h232
`define PMX_FN_ALARM_CH4 10'h233
`define PMX_FN_AUXPDM_CLK 10'h280
`define PMX_FN_AUXPDM_DAT 10'h281

// -----------------------------------------------------------------------------
// Pin numbers (one-based) that limit where codes are valid.
// -----------------------------------------------------------------------------
`define PMX_PIN_ALT_FIRST 3
`define PMX_PIN_LOW_LAST 4
`define PMX_PIN_AUXCLK_A 3
`define PMX_PIN_AUXCLK_B 10
`define PMX_PIN_AUXDAT_A 4
`define PMX_PIN_AUXDAT_B 9

// -----------------------------------------------------------------------------
// Reset values.
// -----------------------------------------------------------------------------
`define PMX_RST_BIT 1'b0
// Cycles before the pad pipeline holds real samples after reset.
`define PMX_SETTLE_CYCLES 3

`endif

// File: verilog/pinmux_pkg.sv
// Types shared by the pin function multiplexer files.
package pinmux_pkg;
    // One function-select code per pin.
    typedef logic [9:0] fn_code_t;
    // One bit per pin.
    typedef logic [15:0] pin_vec_t;
endpackage
